// ### rtl/conv_ctrl.sv
`timescale 1ns/1ps

module conv_ctrl #(
    parameter int TRIG_SRC_COUNT = 16
) (
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic [3:0]                   addr_i,
    input  wire logic [7:0]                   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [7:0]                   rdata_o,
    input  wire logic [TRIG_SRC_COUNT-1:0]    trig_src_i,
    input  wire logic [9:0]                   sar_code_i,
    input  wire logic                         cmp_pin_i,
    output logic                              cmp_pin_buf_en_o,
    output conv_ctrl_pkg::cmp_neg_sel_t       cmp_neg_sel_o,
    output logic      [2:0]                   conv_channel_o,
    output logic      [1:0]                   conv_reference_o,
    output logic                              conv_sample_o,
    output logic                              conv_active_o,
    output logic                              done_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register request and storage

    conv_ctrl_pkg::reg_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Software-visible control state
    logic [7:0] mux_select_reg;
    logic [7:0] converter_ctrl_b_reg;
    logic [7:0] digital_input_disable_one_reg;
    logic [2:0] prescale_sel_reg;
    logic       done_ie_reg;
    logic       auto_trigger_enable_reg;
    logic       converter_enable_reg;
    logic       conversion_done_flag_reg;

    // Sequencer state
    logic       busy_reg;
    logic       first_reg;

    // Result bytes and read-order lock
    logic [7:0] result_low_byte_reg;
    logic [7:0] result_high_byte_reg;
    logic       lock_reg;

    // Selections seen by the converter
    logic [2:0] ch_latched_reg;
    logic [1:0] ref_latched_reg;

    // Divider and conversion counter
    logic [6:0] presc_cnt_reg;
    logic [4:0] cyc_cnt_reg;

    // Trigger history and pin synchroniser
    logic       trig_prev_reg;
    logic       pin_meta_reg;
    logic       pin_sync_reg;

    // Address match shared by the write and result-lock decodes; the read mux decodes addr itself
    function automatic logic hit(input conv_ctrl_pkg::reg_req_t r, input logic [3:0] a);
        hit = r.addr == a;
    endfunction : hit

    // Decoded strobes and sequencer events
    logic wr_a;
    logic start_wr;
    logic enable_next;
    logic conv_tick;
    logic conv_end;
    logic trig_sel;
    logic trig_edge;
    logic start_now;
    logic [15:0] left_word;
    logic [15:0] right_word;

    assign wr_a        = req.wr && hit(req, conv_ctrl_pkg::ADDR_CTRL_A);
    // Enable and start may come in one write, so start looks at the written enable
    assign enable_next = wr_a ? req.wdata[conv_ctrl_pkg::CA_ENABLE] : converter_enable_reg;
    assign start_wr    = wr_a && req.wdata[conv_ctrl_pkg::CA_START]
                         && req.wdata[conv_ctrl_pkg::CA_ENABLE];

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mux_select_reg                <= conv_ctrl_pkg::RESET_BYTE;
            converter_ctrl_b_reg          <= conv_ctrl_pkg::RESET_BYTE;
            digital_input_disable_one_reg <= conv_ctrl_pkg::RESET_BYTE;
            prescale_sel_reg              <= 3'h0;
            done_ie_reg                   <= 1'b0;
            auto_trigger_enable_reg       <= 1'b0;
            converter_enable_reg          <= 1'b0;
        end
        else if (req.wr)
        begin
            if (hit(req, conv_ctrl_pkg::ADDR_MUX_SELECT))
                mux_select_reg <= req.wdata;
            if (hit(req, conv_ctrl_pkg::ADDR_CTRL_B))
                converter_ctrl_b_reg <= req.wdata;
            if (hit(req, conv_ctrl_pkg::ADDR_DIDR_ONE))
                digital_input_disable_one_reg <= req.wdata;
            if (wr_a)
            begin
                prescale_sel_reg        <= req.wdata[conv_ctrl_pkg::CA_PRESC_LSB +: 3];
                done_ie_reg             <= req.wdata[conv_ctrl_pkg::CA_DONE_IE];
                auto_trigger_enable_reg <= req.wdata[conv_ctrl_pkg::CA_AUTO_TRIG];
                converter_enable_reg    <= req.wdata[conv_ctrl_pkg::CA_ENABLE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: divide ratio 2^sel (sel 0 treated as 2), one-cycle tick

    logic [6:0] presc_mask;
    always_comb
    begin
        presc_mask = 7'h01;
        if (prescale_sel_reg != 3'h0)
            presc_mask = 7'((8'h01 << prescale_sel_reg) - 8'h01);
    end

    assign conv_tick = converter_enable_reg && ((presc_cnt_reg & presc_mask) == presc_mask);

    // A trigger edge restarts the divider, fixing its delay to the sample
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            presc_cnt_reg <= 7'h00;
        else if (!converter_enable_reg || trig_edge)
            presc_cnt_reg <= 7'h00;
        else
            presc_cnt_reg <= presc_cnt_reg + 7'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection and edge detection

    always_comb
    begin
        trig_sel = 1'b0;
        if (converter_ctrl_b_reg[conv_ctrl_pkg::CB_TRIG_LSB +: 4] == conv_ctrl_pkg::TRIG_DONE_FLAG)
            trig_sel = 1'b0;
        // Codes past the last source select none
        else if (32'(converter_ctrl_b_reg[conv_ctrl_pkg::CB_TRIG_LSB +: 4]) < TRIG_SRC_COUNT)
            trig_sel = trig_src_i[converter_ctrl_b_reg[conv_ctrl_pkg::CB_TRIG_LSB +: 4]];
    end

    // Done flag as source: conversions chain on their own, no edge needed
    logic free_running;
    assign free_running = auto_trigger_enable_reg && converter_ctrl_b_reg
        [conv_ctrl_pkg::CB_TRIG_LSB +: 4] == conv_ctrl_pkg::TRIG_DONE_FLAG;

    // Only a fresh rising edge counts, and only when idle
    assign trig_edge = auto_trigger_enable_reg && converter_enable_reg && !free_running
                       && trig_sel && !trig_prev_reg && !busy_reg;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            trig_prev_reg <= 1'b0;
        else
            trig_prev_reg <= trig_sel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    // Starts are refused while busy; trigger edges are gated the same way
    assign start_now = !busy_reg && (start_wr || trig_edge);
    assign conv_end  = busy_reg && conv_tick && cyc_cnt_reg == 5'h01;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_reg    <= 1'b0;
            cyc_cnt_reg <= 5'h00;
            first_reg   <= 1'b1;
        end
        else if (!enable_next)
        begin
            // Clearing enable aborts at once; busy never outlives the enable bit
            busy_reg    <= 1'b0;
            cyc_cnt_reg <= 5'h00;
            first_reg   <= 1'b1;
        end
        else if (start_now)
        begin
            busy_reg    <= 1'b1;
            cyc_cnt_reg <= first_reg ? 5'(conv_ctrl_pkg::FIRST_CYCLES)
                                     : 5'(conv_ctrl_pkg::NORMAL_CYCLES);
            first_reg   <= 1'b0;
        end
        else if (conv_end)
        begin
            // Free running restarts at once and keeps start set
            busy_reg    <= free_running;
            cyc_cnt_reg <= 5'(conv_ctrl_pkg::NORMAL_CYCLES);
        end
        else if (busy_reg && conv_tick)
            cyc_cnt_reg <= cyc_cnt_reg - 5'h01;
    end

    // Selections follow the shadow register only between conversions
    // A start latches too, so the first conversion after enable uses them
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ch_latched_reg  <= 3'h0;
            ref_latched_reg <= 2'h0;
        end
        else if (start_now || (converter_enable_reg && (!busy_reg || conv_end)))
        begin
            ch_latched_reg  <= mux_select_reg[conv_ctrl_pkg::MUX_CH_LSB +: 3];
            ref_latched_reg <= mux_select_reg[conv_ctrl_pkg::MUX_REF_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result bytes, read-order lock and done flag

    assign right_word = {6'h00, sar_code_i};
    assign left_word  = {sar_code_i, 6'h00};

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            result_low_byte_reg  <= conv_ctrl_pkg::RESET_BYTE;
            result_high_byte_reg <= conv_ctrl_pkg::RESET_BYTE;
        end
        else if (conv_end && !lock_reg)
        begin
            // Justification follows the live register at conversion end
            if (mux_select_reg[conv_ctrl_pkg::MUX_LEFT_ADJ])
            begin
                result_high_byte_reg <= left_word[15:8];
                result_low_byte_reg  <= left_word[7:0];
            end
            else
            begin
                result_high_byte_reg <= right_word[15:8];
                result_low_byte_reg  <= right_word[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            lock_reg <= 1'b0;
        // A repeated low read keeps the lock; only a high read opens it
        else if (req.rd && hit(req, conv_ctrl_pkg::ADDR_RESULT_LO))
            lock_reg <= 1'b1;
        else if (req.rd && hit(req, conv_ctrl_pkg::ADDR_RESULT_HI))
            lock_reg <= 1'b0;
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            conversion_done_flag_reg <= 1'b0;
        else if (conv_end)
            conversion_done_flag_reg <= 1'b1;
        else if (wr_a && req.wdata[conv_ctrl_pkg::CA_DONE_FLAG])
            conversion_done_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparator pin and negative input routing

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= cmp_pin_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Disable bit gates both the buffer and the pin's read-back
    logic pin_disabled;
    assign pin_disabled     = digital_input_disable_one_reg[conv_ctrl_pkg::DID_CMP_PIN];
    assign cmp_pin_buf_en_o = !pin_disabled;

    always_comb
    begin
        cmp_neg_sel_o = '{bandgap: 1'b1, pin_valid: 1'b0, pin_index: 3'h0};
        if (converter_ctrl_b_reg[conv_ctrl_pkg::CB_CMP_MUX_EN] && !converter_enable_reg)
        begin
            cmp_neg_sel_o.bandgap   = 1'b0;
            cmp_neg_sel_o.pin_index = mux_select_reg[conv_ctrl_pkg::MUX_CH_LSB +: 3];
            cmp_neg_sel_o.pin_valid = mux_select_reg[conv_ctrl_pkg::MUX_CH_LSB + 2]
                || !mux_select_reg[conv_ctrl_pkg::MUX_CH_LSB + 1];
        end
    end

    assign conv_channel_o   = ch_latched_reg;
    assign conv_reference_o = ref_latched_reg;
    // Analog core hands over its next code on this pulse
    assign conv_sample_o    = conv_end;
    assign conv_active_o    = busy_reg;
    // The flag sets with its enable clear; only the request line is gated
    assign done_irq_o       = conversion_done_flag_reg && done_ie_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                conv_ctrl_pkg::ADDR_MUX_SELECT: rdata_o <= mux_select_reg;
                conv_ctrl_pkg::ADDR_CTRL_A:     rdata_o <= {converter_enable_reg, busy_reg,
                    auto_trigger_enable_reg, conversion_done_flag_reg, done_ie_reg,
                    prescale_sel_reg};
                conv_ctrl_pkg::ADDR_CTRL_B:     rdata_o <= converter_ctrl_b_reg;
                conv_ctrl_pkg::ADDR_RESULT_LO:  rdata_o <= result_low_byte_reg;
                conv_ctrl_pkg::ADDR_RESULT_HI:  rdata_o <= result_high_byte_reg;
                conv_ctrl_pkg::ADDR_DIDR_ONE:   rdata_o <= digital_input_disable_one_reg;
                // Pin bit reads zero while its input buffer is off
                conv_ctrl_pkg::ADDR_PIN_IN:     rdata_o <= {7'h00,
                    pin_sync_reg && !pin_disabled};
                default:                        rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

endmodule : conv_ctrl

// ### rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_MUX_SELECT = 4'h0;
    localparam logic [3:0] ADDR_CTRL_A     = 4'h1;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h2;
    localparam logic [3:0] ADDR_RESULT_LO  = 4'h3;
    localparam logic [3:0] ADDR_RESULT_HI  = 4'h4;
    localparam logic [3:0] ADDR_DIDR_ONE   = 4'h5;
    localparam logic [3:0] ADDR_PIN_IN     = 4'h6;

    // mux_select_reg fields
    localparam int MUX_CH_LSB    = 0;
    localparam int MUX_LEFT_ADJ  = 5;
    localparam int MUX_REF_LSB   = 6;
    // converter_ctrl_a fields
    localparam int CA_PRESC_LSB  = 0;
    localparam int CA_DONE_IE    = 3;
    localparam int CA_DONE_FLAG  = 4;
    localparam int CA_AUTO_TRIG  = 5;
    localparam int CA_START      = 6;
    localparam int CA_ENABLE     = 7;
    // converter_ctrl_b fields
    localparam int CB_TRIG_LSB   = 0;
    localparam int CB_CMP_MUX_EN = 6;
    // digital_input_disable_one fields
    localparam int DID_CMP_PIN   = 0;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Converter timing in converter clock cycles, and result width in bits
    localparam int NORMAL_CYCLES = 13;
    localparam int FIRST_CYCLES  = 25;
    localparam int RESULT_BITS   = 10;

    // Trigger source code that selects the conversion-done flag
    localparam logic [3:0] TRIG_DONE_FLAG = 4'h0;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       bandgap;
        logic       pin_valid;
        logic [2:0] pin_index;
    } cmp_neg_sel_t;

endpackage : conv_ctrl_pkg

// ### test/conv_ctrl_sva.sv
`timescale 1ns/1ps
module conv_ctrl_sva #(
    parameter int TRIG_SRC_COUNT = 16
) (
    input wire logic                        ref_clk_i,
    input wire logic                        rst_b_i,
    input wire logic [3:0]                  addr_i,
    input wire logic [7:0]                  wdata_i,
    input wire logic                        wr_i,
    input wire logic                        cmp_pin_buf_en_o,
    input wire conv_ctrl_pkg::cmp_neg_sel_t cmp_neg_sel_o,
    input wire logic [2:0]                  conv_channel_o,
    input wire logic [1:0]                  conv_reference_o,
    input wire logic                        conv_sample_o,
    input wire logic                        conv_active_o,
    input wire logic                        done_irq_o
);
    logic       en_reg;
    logic       mux_en_reg;
    logic       did_reg;
    logic       ie_reg;
    logic [2:0] ch_reg;
    logic       start_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control bits, rebuilt from bus writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            en_reg     <= 1'b0;
            mux_en_reg <= 1'b0;
            did_reg    <= 1'b0;
            ie_reg     <= 1'b0;
            ch_reg     <= 3'h0;
        end
        else if (wr_i)
        begin
            if (addr_i == conv_ctrl_pkg::ADDR_CTRL_A) en_reg <= wdata_i[7];
            if (addr_i == conv_ctrl_pkg::ADDR_CTRL_A) ie_reg <= wdata_i[3];
            if (addr_i == conv_ctrl_pkg::ADDR_CTRL_B) mux_en_reg <= wdata_i[6];
            if (addr_i == conv_ctrl_pkg::ADDR_DIDR_ONE) did_reg <= wdata_i[0];
            if (addr_i == conv_ctrl_pkg::ADDR_MUX_SELECT) ch_reg <= wdata_i[2:0];
        end
    end

    assign start_wr = wr_i && addr_i == conv_ctrl_pkg::ADDR_CTRL_A && wdata_i[7] && wdata_i[6];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    bandgap_sel_a: assert property ((!mux_en_reg || en_reg) |-> cmp_neg_sel_o.bandgap)
        else $error("comparator negative input not on bandgap");
    pin_select_a: assert property ((mux_en_reg && !en_reg) |-> !cmp_neg_sel_o.bandgap
        && cmp_neg_sel_o.pin_valid == (ch_reg[2:1] != 2'h1)
        && (!cmp_neg_sel_o.pin_valid || cmp_neg_sel_o.pin_index == ch_reg))
        else $error("comparator pin selection wrong");
    buf_disable_a: assert property (cmp_pin_buf_en_o == !did_reg)
        else $error("input buffer enable wrong");
    sel_frozen_a: assert property ((!en_reg && !$past(en_reg))
        |-> $stable(conv_reference_o) && $stable(conv_channel_o))
        else $error("selection applied while converter off");
    chan_hold_a: assert property (($past(conv_active_o) && conv_active_o
        && !$past(conv_sample_o)) |-> $stable(conv_channel_o))
        else $error("channel changed mid conversion");
    done_flag_a: assert property ((conv_sample_o && ie_reg) |=> done_irq_o)
        else $error("done not flagged at conversion end");
    busy_min_a: assert property ($rose(conv_active_o)
        |-> (conv_active_o && !conv_sample_o) [*8])
        else $error("conversion ended too early");
    sample_busy_a: assert property (conv_sample_o |-> conv_active_o)
        else $error("conversion end without busy");
    off_idle_a: assert property (!en_reg |-> !conv_active_o && !conv_sample_o)
        else $error("conversion while converter off");
    start_busy_a: assert property ((start_wr && !conv_active_o) |=> conv_active_o)
        else $error("start write did not begin conversion");

    cover property (conv_sample_o && ie_reg);
    cover property ($rose(conv_active_o) && !$past(wr_i));
    cover property (mux_en_reg && !en_reg && cmp_neg_sel_o.pin_valid);
endmodule : conv_ctrl_sva

// ### test/conv_partner.sv
`timescale 1ns/1ps
module conv_partner #(
    parameter int TRIG_SRC_COUNT = 16
) (
    input wire logic                      clk_i,
    input wire logic                      rst_b_i,
    input wire logic                      sample_i,
    input wire logic                      event_i,
    input wire logic [3:0]                event_idx_i,
    input wire logic                      clear_i,
    output logic     [9:0]                code_o,
    output logic     [TRIG_SRC_COUNT-1:0] flags_o
);
    // Code moves only after a sample, so it is steady through each conversion
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            code_o <= 10'h2A5;
        else if (sample_i)
            code_o <= 10'($urandom);
    end

    // Flags set on events whatever the masks; software clears them to re-arm
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            flags_o <= '0;
        else if (event_i)
            flags_o[event_idx_i] <= 1'b1;
        else if (clear_i)
            flags_o <= '0;
    end
endmodule : conv_partner

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int TRIG_SRC_COUNT = 16;
    logic                        ref_clk_i = 1'b0;
    logic                        rst_b_i   = 1'b0;
    logic [3:0]                  addr_i    = 4'h0;
    logic [7:0]                  wdata_i   = 8'h00;
    logic                        wr_i      = 1'b0;
    logic                        rd_i      = 1'b0;
    logic                        cmp_pin_i = 1'b0;
    logic                        ev_req    = 1'b0;
    logic                        ev_clr    = 1'b0;
    logic [3:0]                  ev_idx    = 4'h1;
    logic [7:0]                  rdata_o;
    logic [TRIG_SRC_COUNT-1:0]   trig_src_i;
    logic [9:0]                  sar_code_i;
    logic                        cmp_pin_buf_en_o;
    conv_ctrl_pkg::cmp_neg_sel_t cmp_neg_sel_o;
    logic [2:0]                  conv_channel_o;
    logic [1:0]                  conv_reference_o;
    logic                        conv_sample_o;
    logic                        conv_active_o;
    logic                        done_irq_o;
    logic [7:0]                  exp_q[$];
    logic                        rd_d = 1'b0;
    logic [9:0]                  last_code;
    logic [9:0]                  c1;
    realtime                     t0;
    int                          miscompares = 0;
    int                          cmp_count   = 0;
    int                          samples     = 0;
    int                          s0;

    conv_ctrl #(.TRIG_SRC_COUNT(TRIG_SRC_COUNT)) conv_ctrl_i (.ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .trig_src_i(trig_src_i), .sar_code_i(sar_code_i),
        .cmp_pin_i(cmp_pin_i), .cmp_pin_buf_en_o(cmp_pin_buf_en_o),
        .cmp_neg_sel_o(cmp_neg_sel_o), .conv_channel_o(conv_channel_o),
        .conv_reference_o(conv_reference_o), .conv_sample_o(conv_sample_o),
        .conv_active_o(conv_active_o), .done_irq_o(done_irq_o));
    conv_partner #(.TRIG_SRC_COUNT(TRIG_SRC_COUNT)) conv_partner_i (.clk_i(ref_clk_i),
        .rst_b_i(rst_b_i), .sample_i(conv_sample_o), .event_i(ev_req), .event_idx_i(ev_idx),
        .clear_i(ev_clr), .code_o(sar_code_i), .flags_o(trig_src_i));

    always #5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
    endtask : rd

    task automatic pulse(input logic clr);
        @(posedge ref_clk_i);
        if (clr) ev_clr <= 1'b1;
        else ev_req <= 1'b1;
        @(posedge ref_clk_i);
        ev_clr <= 1'b0;
        ev_req <= 1'b0;
    endtask : pulse

    // Conversion length is measured from the start write, bus reads in between
    task automatic wait_conv(input int ticks);
        int n;
        n = 0;
        while (conv_sample_o !== 1'b1 && n < 4000)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        n = int'(($realtime - t0) / 10.0);
        chk(16'(n >= 2 * ticks - 4 && n <= 2 * ticks + 4), 16'h0001);
        @(posedge ref_clk_i);
        #1;
    endtask : wait_conv

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk_i)
    begin
        rd_d <= rd_i;
        if (conv_sample_o === 1'b1)
        begin
            samples++;
            last_code = sar_code_i;
        end
        if (rd_d === 1'b1)
            chk(16'(rdata_o), 16'(exp_q.pop_front()));
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        complete_run();
    end

    initial
    begin
        void'($urandom(94));
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rd(conv_ctrl_pkg::ADDR_CTRL_A, 8'h00);
        rd(conv_ctrl_pkg::ADDR_DIDR_ONE, 8'h00);
        rd(4'hF, 8'h00);
        wr(conv_ctrl_pkg::ADDR_CTRL_B, 8'h40);
        for (int c = 0; c < 8; c++)
        begin
            wr(conv_ctrl_pkg::ADDR_MUX_SELECT, 8'(c));
            #1;
            chk(16'(cmp_neg_sel_o.bandgap), 16'h0000);
            chk(16'(cmp_neg_sel_o.pin_valid), 16'(c / 2 != 1));
            if (c / 2 != 1) chk(16'(cmp_neg_sel_o.pin_index), 16'(c));
        end
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'h80);
        #1;
        chk(16'(cmp_neg_sel_o.bandgap), 16'h0001);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'h00);
        wr(conv_ctrl_pkg::ADDR_CTRL_B, 8'h00);
        #1;
        chk(16'(cmp_neg_sel_o.bandgap), 16'h0001);
        @(posedge ref_clk_i) cmp_pin_i <= 1'b1;
        wr(conv_ctrl_pkg::ADDR_DIDR_ONE, 8'h01);
        #1;
        chk(16'(cmp_pin_buf_en_o), 16'h0000);
        rd(conv_ctrl_pkg::ADDR_PIN_IN, 8'h00);
        wr(conv_ctrl_pkg::ADDR_DIDR_ONE, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        rd(conv_ctrl_pkg::ADDR_PIN_IN, 8'h01);
        $display("test comparator done");
        wr(conv_ctrl_pkg::ADDR_MUX_SELECT, 8'h45);
        #1;
        chk(16'({conv_reference_o, conv_channel_o}), 16'h0007);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hC8);
        t0 = $realtime - 10.0;
        rd(conv_ctrl_pkg::ADDR_CTRL_A, 8'hC8);
        wait_conv(25);
        chk(16'({conv_reference_o, conv_channel_o}), 16'h000D);
        chk(16'(done_irq_o), 16'h0001);
        rd(conv_ctrl_pkg::ADDR_CTRL_A, 8'h98);
        rd(conv_ctrl_pkg::ADDR_RESULT_LO, last_code[7:0]);
        rd(conv_ctrl_pkg::ADDR_RESULT_HI, {6'h00, last_code[9:8]});
        wr(conv_ctrl_pkg::ADDR_MUX_SELECT, 8'h65);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hD8);
        t0 = $realtime - 10.0;
        wr(conv_ctrl_pkg::ADDR_MUX_SELECT, 8'h62);
        #1;
        chk(16'(conv_channel_o), 16'h0005);
        wait_conv(13);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(16'(conv_channel_o), 16'h0002);
        c1 = last_code;
        rd(conv_ctrl_pkg::ADDR_RESULT_LO, {c1[1:0], 6'h00});
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hD8);
        t0 = $realtime - 10.0;
        wait_conv(13);
        chk(16'(done_irq_o), 16'h0001);
        rd(conv_ctrl_pkg::ADDR_RESULT_LO, {c1[1:0], 6'h00});
        rd(conv_ctrl_pkg::ADDR_RESULT_HI, c1[9:2]);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hDA);
        t0 = $realtime - 10.0;
        wait_conv(26);
        rd(conv_ctrl_pkg::ADDR_RESULT_HI, last_code[9:2]);
        $display("test conversion done");
        ev_idx <= 4'(1 + $urandom % 15);
        #1;
        wr(conv_ctrl_pkg::ADDR_CTRL_B, {4'h0, ev_idx});
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hB0);
        s0 = samples;
        pulse(1'b0);
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk(16'(conv_active_o), 16'h0001);
        pulse(1'b1);
        pulse(1'b0);
        repeat (150) @(posedge ref_clk_i);
        chk(16'(samples - s0), 16'h0001);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hE0);
        repeat (60) @(posedge ref_clk_i);
        chk(16'(samples - s0), 16'h0002);
        pulse(1'b1);
        pulse(1'b0);
        repeat (60) @(posedge ref_clk_i);
        chk(16'(samples - s0), 16'h0003);
        $display("test trigger done");
        wr(conv_ctrl_pkg::ADDR_CTRL_B, 8'h00);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'hF0);
        s0 = samples;
        repeat (200) @(posedge ref_clk_i);
        chk(16'(samples - s0 >= 5), 16'h0001);
        rd(conv_ctrl_pkg::ADDR_CTRL_A, 8'hF0);
        wr(conv_ctrl_pkg::ADDR_CTRL_A, 8'h10);
        repeat (3) @(posedge ref_clk_i);
        $display("test free run done");
        complete_run();
    end
endmodule : testbench

bind conv_ctrl conv_ctrl_sva #(.TRIG_SRC_COUNT(TRIG_SRC_COUNT)) conv_ctrl_sva_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .cmp_pin_buf_en_o(cmp_pin_buf_en_o), .cmp_neg_sel_o(cmp_neg_sel_o),
    .conv_channel_o(conv_channel_o), .conv_reference_o(conv_reference_o),
    .conv_sample_o(conv_sample_o), .conv_active_o(conv_active_o), .done_irq_o(done_irq_o));
